/* File: common/hcmd_pkg.sv */
// Package for the host command register block: offsets, fields, resets,
// timing counts. Assumes an APB slave with 32-bit data.
package hcmd_pkg;
  // ****************
  // Register offsets
  // ****************
  localparam logic [7:0] HCMD_CMD_OFF = 8'h10;
  localparam logic [7:0] HCMD_STS_OFF = 8'h14;
  localparam logic [7:0] HCMD_IEN_OFF = 8'h18;
  localparam logic [7:0] HCMD_ICLR_OFF = 8'h1c;
  localparam logic [7:0] HCMD_EDGE_OFF = 8'h20;
  // ****************
  // Command fields
  // ****************
  localparam int HCMD_RS_BIT = 0;
  localparam int HCMD_SRST_BIT = 1;
  localparam int HCMD_FLL_LO = 2;
  localparam int HCMD_PEN_BIT = 4;
  localparam int HCMD_AEN_BIT = 5;
  localparam int HCMD_DB_BIT = 6;
  localparam int HCMD_PKC_LO = 8;
  localparam int HCMD_PKE_BIT = 11;
  localparam int HCMD_THR_LO = 16;
  localparam logic [31:0] HCMD_CMD_MASK = 32'h00ff0b7f;
  localparam logic [31:0] HCMD_CMD_RESET = 32'h00080b00;
  // ****************
  // Status / interrupt fields
  // ****************
  localparam int HCMD_EV_W = 2;
  localparam int HCMD_EV_AADV = 0;
  localparam int HCMD_EV_THR = 1;
  localparam int HCMD_HALT_BIT = 12;
  localparam logic [7:0] HCMD_EDGE_RESET = 8'h1f;
  // ****************
  // Timing
  // ****************
  localparam int HCMD_CLK_MHZ = 25;
  localparam int HCMD_UFRAME_NS = 125000;
  localparam int HCMD_UFRAME_CYC = HCMD_UFRAME_NS * HCMD_CLK_MHZ / 1000;
  localparam int HCMD_STOP_CYC = 4;
  localparam int HCMD_SRST_CYC = 8;
endpackage : hcmd_pkg

/* File: verilog/hcmd_pacer.sv */
// Interrupt pacing: holds schedule events until the threshold interval (none at full speed)
// and, in edge mode, the minimum width have passed. Assumes synchronous reset.
`timescale 1ns/1ns
module hcmd_pacer
  import hcmd_pkg::*;
#(
  parameter int UFRAME_CYC = HCMD_UFRAME_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic event_i,
  input wire logic [7:0] thresh_i,
  input wire logic full_speed_i,
  input wire logic edge_mode_i,
  input wire logic [7:0] min_width_i,
  output logic fire_o
);
  logic [15:0] cyc_reg;
  logic [7:0] uf_reg;
  logic pend_reg;
  logic fire_reg;
  wire uf_tick = (cyc_reg == 16'(UFRAME_CYC - 1));
  // Full speed ignores the threshold entirely
  wire [7:0] need = full_speed_i ? 8'h01 : thresh_i;
  // Edge mode adds the minimum pulse width gate
  wire [7:0] gate = (edge_mode_i && min_width_i > need) ? min_width_i : need;
  wire ready = (need <= 8'h01 && !edge_mode_i) || uf_reg >= gate;
  wire send = (pend_reg || event_i) && ready;
  assign fire_o = fire_reg;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cyc_reg <= 16'h0000;
      uf_reg <= 8'h00;
      pend_reg <= 1'b0;
      fire_reg <= 1'b0;
    end
    else
    begin
      cyc_reg <= uf_tick ? 16'h0000 : cyc_reg + 16'h0001;
      if (send)
        uf_reg <= 8'h00;
      else if (uf_tick && uf_reg != 8'hff)
        uf_reg <= uf_reg + 8'h01;
      pend_reg <= (pend_reg || event_i) && !send;
      fire_reg <= send;
    end
  end
endmodule : hcmd_pacer

/* File: verilog/hcmd_regs.sv */
// Host command register bank on APB with status, interrupt and pacing.
// Assumes a single 25 MHz clock and the schedule engine outside.
//
// Behaviour
// - Command writes act on their fields; a write with bit 1 set loads reset values
// - Threshold bits 23:16, reset 08h, pace interrupts
// - Threshold encodings 01h..40h; software writes only those
// - Edge mode adds minimum pulse width gate
// - Threshold ignored at full speed
// - Park enable bit 11, reset one
// - Park count bits 9:8, reset 11b
// - Doorbell bit 6 interrupts at next advance
// - Bit 5 enables async schedule from pointer
// - Bit 4 enables periodic schedule via base
// - Frame list length 1024/512/256; 11 reserved
// - Bit 1 write resets controller logic
// - Bit 0 runs or stops schedules
// - Halted zero while running, one once stopped
// - Advance event is write-one-clear status bit
`timescale 1ns/1ns
module hcmd_regs
  import hcmd_pkg::*;
#(
  parameter int UFRAME_CYC = HCMD_UFRAME_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic async_advance_i,
  input wire logic sched_event_i,
  input wire logic sched_idle_i,
  input wire logic full_speed_i,
  output logic run_stop_o,
  output logic controller_soft_reset_o,
  output logic async_list_enable_o,
  output logic periodic_list_enable_o,
  output logic [1:0] frame_list_length_o,
  output logic [10:0] frame_list_entries_o,
  output logic queue_park_enable_o,
  output logic [1:0] queue_park_count_o,
  output logic controller_halted_o,
  output logic sched_irq_o,
  output logic irq_o
);
  // ****************
  // Helpers
  // ****************
  function automatic logic [10:0] hcmd_entries(input logic [1:0] sel);
    case (sel)
      2'b00: hcmd_entries = 11'h400;
      2'b01: hcmd_entries = 11'h200;
      2'b10: hcmd_entries = 11'h100;
      default: hcmd_entries = 11'h000;
    endcase
  endfunction : hcmd_entries

  typedef enum logic [1:0] {
    HCMD_HALTED = 2'b00,
    HCMD_RUNNING = 2'b01,
    HCMD_STOPPING = 2'b10
  } hcmd_state_t;

  // ****************
  // Bus decode
  // ****************
  wire wr = psel && penable && pwrite;
  wire hit_cmd = paddr == HCMD_CMD_OFF;
  wire hit_sts = paddr == HCMD_STS_OFF;
  wire hit_ien = paddr == HCMD_IEN_OFF;
  wire hit_iclr = paddr == HCMD_ICLR_OFF;
  wire hit_edge = paddr == HCMD_EDGE_OFF;
  wire mapped = hit_cmd || hit_sts || hit_ien || hit_iclr || hit_edge;
  wire wr_cmd = wr && hit_cmd;
  wire wr_sts = wr && hit_sts;
  wire wr_iclr = wr && hit_iclr;

  // ****************
  // Registers
  // ****************
  logic [31:0] cmd_reg;
  logic [31:0] cmd_next;
  logic [HCMD_EV_W-1:0] ev_reg;
  logic [HCMD_EV_W-1:0] ev_next;
  logic [HCMD_EV_W-1:0] ien_reg;
  logic [8:0] edge_reg;
  logic db_pend_reg;
  logic [3:0] srst_reg;
  logic [2:0] stop_reg;
  hcmd_state_t state_reg;
  hcmd_state_t state_next;
  logic [31:0] rdata;
  logic fire;

  wire srst_busy = srst_reg != 4'h0;
  // Reserved bits dropped on write; doorbell self-clears
  wire [31:0] wmask = pwdata & HCMD_CMD_MASK;
  wire cmd_rs = cmd_reg[HCMD_RS_BIT];

  // Doorbell stays set until the advance is seen
  always_comb
  begin
    cmd_next = cmd_reg;
    if (wr_cmd)
      cmd_next = wmask;
    if (wr_cmd && wmask[HCMD_SRST_BIT])
      cmd_next = HCMD_CMD_RESET | 32'h00000002;
    if (!srst_busy && cmd_reg[HCMD_SRST_BIT] && !wr_cmd)
      cmd_next[HCMD_SRST_BIT] = 1'b0;
    if (db_pend_reg && async_advance_i && !wr_cmd)
      cmd_next[HCMD_DB_BIT] = 1'b0;
  end

  // Set beats clear for sticky events
  wire db_hit = db_pend_reg && async_advance_i;
  wire [HCMD_EV_W-1:0] ev_set = {fire, db_hit};
  wire [HCMD_EV_W-1:0] clr_sts = wr_sts ? {1'b0, pwdata[5]} : 2'b00;
  wire [HCMD_EV_W-1:0] clr_i = wr_iclr ? pwdata[1:0] : 2'b00;
  assign ev_next = (ev_reg & ~(clr_sts | clr_i)) | ev_set;

  // ****************
  // Run / stop
  // ****************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      HCMD_HALTED:
        if (cmd_rs)
          state_next = HCMD_RUNNING;
      HCMD_RUNNING:
        if (!cmd_rs)
          state_next = HCMD_STOPPING;
      HCMD_STOPPING:
        if (cmd_rs)
          state_next = HCMD_RUNNING;
        else if (sched_idle_i && stop_reg == 3'(HCMD_STOP_CYC - 1))
          state_next = HCMD_HALTED;
      default:
        state_next = HCMD_HALTED;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || (srst_busy && srst_reg == 4'h1))
    begin
      cmd_reg <= HCMD_CMD_RESET;
      state_reg <= HCMD_HALTED;
      stop_reg <= 3'h0;
      db_pend_reg <= 1'b0;
    end
    else
    begin
      cmd_reg <= cmd_next;
      state_reg <= state_next;
      stop_reg <= (state_reg == HCMD_STOPPING) ? stop_reg + 3'h1 : 3'h0;
      db_pend_reg <= cmd_next[HCMD_DB_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ev_reg <= 2'b00;
      ien_reg <= 2'b00;
      edge_reg <= {1'b0, HCMD_EDGE_RESET};
      srst_reg <= 4'h0;
    end
    else
    begin
      ev_reg <= ev_next;
      if (wr && hit_ien)
        ien_reg <= pwdata[1:0];
      if (wr && hit_edge)
        edge_reg <= pwdata[8:0];
      // Soft reset held a few cycles so engines see it
      if (wr_cmd && wmask[HCMD_SRST_BIT])
        srst_reg <= 4'(HCMD_SRST_CYC);
      else if (srst_busy)
        srst_reg <= srst_reg - 4'h1;
    end
  end

  // ****************
  // Pacing
  // ****************
  hcmd_pacer #(
    .UFRAME_CYC(UFRAME_CYC)
  ) u_pacer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .event_i(sched_event_i && cmd_rs),
    .thresh_i(cmd_reg[HCMD_THR_LO +: 8]),
    .full_speed_i(full_speed_i),
    .edge_mode_i(edge_reg[8]),
    .min_width_i(edge_reg[7:0]),
    .fire_o(fire)
  );

  // ****************
  // Read back and outputs
  // ****************
  wire halted = state_reg == HCMD_HALTED;
  wire [31:0] sts_word = {19'h0, halted, 6'h0, ev_reg[HCMD_EV_AADV], 5'h0};
  assign rdata = hit_cmd ? (cmd_reg & HCMD_CMD_MASK) :
                 hit_sts ? sts_word :
                 hit_ien ? {30'h0, ien_reg} :
                 hit_edge ? {23'h0, edge_reg} : 32'h0;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= rdata;
  end

  assign run_stop_o = cmd_rs && !srst_busy;
  assign controller_soft_reset_o = srst_busy;
  assign async_list_enable_o = cmd_reg[HCMD_AEN_BIT];
  assign periodic_list_enable_o = cmd_reg[HCMD_PEN_BIT];
  assign frame_list_length_o = cmd_reg[HCMD_FLL_LO +: 2];
  assign frame_list_entries_o = hcmd_entries(cmd_reg[HCMD_FLL_LO +: 2]);
  assign queue_park_enable_o = cmd_reg[HCMD_PKE_BIT];
  assign queue_park_count_o = cmd_reg[HCMD_PKC_LO +: 2];
  assign controller_halted_o = halted;
  assign sched_irq_o = fire;
  assign irq_o = |(ev_reg & ien_reg);

  // ****************
  // Checks
  // ****************
  halt_when_run_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == HCMD_RUNNING) |-> !controller_halted_o)
    else $error("halted while running");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_reg & ~HCMD_CMD_MASK) == 32'h0)
    else $error("reserved command bits set");
  doorbell_event_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (db_pend_reg && async_advance_i && !srst_busy) |=> ev_reg[HCMD_EV_AADV])
    else $error("advance event lost");
  park_field_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> queue_park_enable_o && queue_park_count_o == 2'b11)
    else $error("park reset value wrong");
  cmd_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_cmd && !wmask[HCMD_SRST_BIT] && !srst_busy) |=>
    cmd_reg[HCMD_THR_LO +: 8] == $past(pwdata[23:16]))
    else $error("threshold write not taken");
  soft_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_cmd && wmask[HCMD_SRST_BIT]) |=> controller_soft_reset_o[*4])
    else $error("soft reset too short");
  run_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_rs && !srst_busy && state_reg == HCMD_HALTED) |=>
    state_reg == HCMD_RUNNING)
    else $error("run not started");
  enables_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    async_list_enable_o == cmd_reg[5] && periodic_list_enable_o == cmd_reg[4])
    else $error("schedule enable mismatch");
endmodule : hcmd_regs

/* File: testbench/tb.sv */
// Self-checking bench for the host command register bank.
// Assumes the APB slave, schedule inputs driven here, short micro-frames.
`timescale 1ns/1ns
module tb;
  import hcmd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic async_advance_i = 1'b0, sched_event_i = 1'b0;
  logic sched_idle_i = 1'b0, full_speed_i = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, run_stop_o, controller_soft_reset_o;
  logic async_list_enable_o, periodic_list_enable_o;
  logic [1:0] frame_list_length_o, queue_park_count_o;
  logic [10:0] frame_list_entries_o;
  logic queue_park_enable_o, controller_halted_o, sched_irq_o, irq_o;
  int fail_count = 0;
  int comparisons = 0;
  int n;
  logic [31:0] rd;
  logic err;

  always #20 clk_i = ~clk_i;

  // Short micro-frame keeps pacing waits to tens of cycles
  hcmd_regs #(.UFRAME_CYC(8)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .async_advance_i(async_advance_i), .sched_event_i(sched_event_i),
    .sched_idle_i(sched_idle_i), .full_speed_i(full_speed_i),
    .run_stop_o(run_stop_o),
    .controller_soft_reset_o(controller_soft_reset_o),
    .async_list_enable_o(async_list_enable_o),
    .periodic_list_enable_o(periodic_list_enable_o),
    .frame_list_length_o(frame_list_length_o),
    .frame_list_entries_o(frame_list_entries_o),
    .queue_park_enable_o(queue_park_enable_o),
    .queue_park_count_o(queue_park_count_o),
    .controller_halted_o(controller_halted_o),
    .sched_irq_o(sched_irq_o), .irq_o(irq_o));

  // ****************
  // Helpers
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask : tick

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  task automatic event_gap(output int cyc);
    @(posedge clk_i);
    sched_event_i <= 1'b1;
    @(posedge clk_i);
    sched_event_i <= 1'b0;
    cyc = 0;
    while (sched_irq_o !== 1'b1 && cyc < 2000)
    begin
      @(posedge clk_i);
      cyc++;
    end
  endtask : event_gap

  task automatic print_verdict;
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    tick(20000);
    fail_count++;
    print_verdict();
  end

  // ****************
  // Test sequence
  // ****************
  initial
  begin
    tick(6);
    rst_n_i <= 1'b1;
    rdchk(HCMD_CMD_OFF, 32'h00080b00);
    rdchk(HCMD_STS_OFF, 32'h00001000);
    check(frame_list_entries_o, 32'h400);
    rdchk(8'h40, 32'h0);
    check(err, 32'h1);
    // Reserved bits set on purpose, must not read back
    wr(HCMD_CMD_OFF, 32'hff20f4b5);
    rdchk(HCMD_CMD_OFF, 32'h00200035);
    check({async_list_enable_o, periodic_list_enable_o}, 32'h3);
    check({queue_park_enable_o, queue_park_count_o}, 32'h0);
    check(run_stop_o, 32'h1);
    check(controller_halted_o, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr(HCMD_CMD_OFF, 32'(i) << 2);
      tick(1);
      check(frame_list_entries_o, 32'h400 >> i);
    end
    tick(10);
    check(controller_halted_o, 32'h0);
    sched_idle_i <= 1'b1;
    tick(10);
    check(controller_halted_o, 32'h1);
    wr(HCMD_IEN_OFF, 32'h1);
    wr(HCMD_CMD_OFF, 32'h00000041);
    rdchk(HCMD_CMD_OFF, 32'h00000041);
    check(irq_o, 32'h0);
    @(posedge clk_i);
    async_advance_i <= 1'b1;
    @(posedge clk_i);
    async_advance_i <= 1'b0;
    tick(3);
    rdchk(HCMD_STS_OFF, 32'h00000020);
    check(irq_o, 32'h1);
    wr(HCMD_IEN_OFF, 32'h0);
    tick(1);
    check(irq_o, 32'h0);
    wr(HCMD_IEN_OFF, 32'h1);
    wr(HCMD_ICLR_OFF, 32'h1);
    tick(1);
    check(irq_o, 32'h0);
    wr(HCMD_CMD_OFF, 32'h00000041);
    @(posedge clk_i);
    async_advance_i <= 1'b1;
    @(posedge clk_i);
    async_advance_i <= 1'b0;
    tick(3);
    wr(HCMD_STS_OFF, 32'h00000020);
    rdchk(HCMD_STS_OFF, 32'h0);
    // Pacing: immediate, two micro-frames, full speed, edge width
    wr(HCMD_CMD_OFF, 32'h00010001);
    event_gap(n);
    check(n <= 4, 32'h1);
    wr(HCMD_CMD_OFF, 32'h00020001);
    event_gap(n);
    event_gap(n);
    check(n >= 6 && n <= 24, 32'h1);
    full_speed_i <= 1'b1;
    event_gap(n);
    event_gap(n);
    check(n <= 4, 32'h1);
    full_speed_i <= 1'b0;
    wr(HCMD_CMD_OFF, 32'h00010001);
    wr(HCMD_EDGE_OFF, 32'h00000104);
    event_gap(n);
    event_gap(n);
    check(n >= 20 && n <= 40, 32'h1);
    wr(HCMD_CMD_OFF, 32'h00000003);
    tick(1);
    check(controller_soft_reset_o, 32'h1);
    check(run_stop_o, 32'h0);
    tick(12);
    check(controller_soft_reset_o, 32'h0);
    rdchk(HCMD_CMD_OFF, 32'h00080b00);
    print_verdict();
  end
endmodule : tb
